/* core/vps_special_reg.sv */
// vps_special_reg.sv: per-port vphy special control/status register
// assumes a register-space access port (32-bit) and a serial management port (16-bit)
`timescale 1ns/1ps
`default_nettype none
`include "vps_regs.svh"
module vps_special_reg #(
	parameter logic [11:0] REG_OFS = `VPS_OFS_PORT0
) (
	input  wire logic               mclk,
	input  wire logic               sys_rst,
	input  wire vps_pkg::vps_strap_s strap_pins,
	input  wire logic               vphy_reset_pulse,
	input  wire logic               vphy_soft_reset_bit,
	input  wire logic               vphy_autoneg_enable,
	input  wire logic               vphy_speed_select_low,
	input  wire logic               mode_a,
	input  wire logic [2:0]         an_result,
	input  wire logic               loopback_in,
	input  wire logic               sys_wr,
	input  wire logic               sys_rd,
	input  wire logic [11:0]        sys_addr,
	input  wire logic [31:0]        sys_wdata,
	output var  logic [31:0]        sys_rdata,
	output var  logic               sys_hit,
	input  wire logic               mii_wr,
	input  wire logic               mii_rd,
	input  wire logic [4:0]         mii_regad,
	input  wire logic [15:0]        mii_wdata,
	output var  logic [15:0]        mii_rdata,
	output var  vps_pkg::vps_ctrl_s ctrl_out,
	output var  logic               port_reference_clock_pin_oe
);
	import vps_pkg::*;

	localparam int SW = $bits(vps_strap_s);

	logic [SW-1:0] strap_sync;
	vps_strap_s    strap_q;
	logic          strap_take_q;
	logic [1:0]    fill_q;
	logic          turbo_q;
	logic          refclk_dir_q;
	logic          clk_drive_q;
	logic          hb_off_q;
	logic [2:0]    speed_duplex;
	logic [15:0]   reg_view;
	logic          sys_sel;
	logic          mii_sel;
	logic          soft_reset;
	logic          wr_any;
	logic [15:0]   wr_data;

	vps_sync #(.W(SW)) u_strap_sync (
		.mclk    (mclk),
		.sys_rst (sys_rst),
		.din     (strap_pins),
		.dout    (strap_sync)
	);

	// straps latched once, after the synchroniser has filled following reset release
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			fill_q       <= '0;
			strap_take_q <= 1'b0;
			strap_q      <= '0;
		end else if (!strap_take_q) begin
			fill_q <= fill_q + 2'h1;
			if (fill_q == 2'(`VPS_SYNC_STAGES)) begin
				strap_take_q <= 1'b1;
				strap_q      <= vps_strap_s'(strap_sync);
			end
		end
	end

	assign soft_reset = vphy_reset_pulse || vphy_soft_reset_bit || !strap_take_q;
	assign sys_sel    = (sys_addr == REG_OFS);
	assign mii_sel    = (mii_regad == `VPS_MII_INDEX);
	assign wr_any     = (sys_wr && sys_sel) || (mii_wr && mii_sel);
	assign wr_data    = (sys_wr && sys_sel) ? sys_wdata[15:0] : mii_wdata;

	// writable fields; strap defaults restored on vphy reset
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			turbo_q      <= 1'b0;
			refclk_dir_q <= 1'b0;
			clk_drive_q  <= 1'b0;
			hb_off_q     <= 1'b0;
		end else if (soft_reset) begin
			turbo_q      <= strap_take_q ? strap_q.turbo      : strap_sync[3];
			refclk_dir_q <= strap_take_q ? strap_q.refclk_dir : strap_sync[2];
			clk_drive_q  <= strap_take_q ? strap_q.clk_drive  : strap_sync[1];
			hb_off_q     <= strap_take_q ? strap_q.hb_off     : strap_sync[0];
		end else if (wr_any) begin
			turbo_q      <= wr_data[`VPS_BIT_TURBO];
			refclk_dir_q <= wr_data[`VPS_BIT_REFCLK_DIR];
			clk_drive_q  <= wr_data[`VPS_BIT_CLK_DRIVE];
			hb_off_q     <= wr_data[`VPS_BIT_HB_OFF];
		end
	end

	// speed/duplex: negotiation result or forced basic control bits
	always_comb begin
		if (vphy_autoneg_enable) begin
			speed_duplex = an_result;
		end else begin
			speed_duplex = {mode_a, vphy_speed_select_low, !vphy_speed_select_low};
		end
	end

	always_comb begin
		reg_view = '0;
		reg_view[`VPS_BIT_MODE2] = strap_q.mode[2];
		reg_view[14] = loopback_in;
		reg_view[`VPS_BIT_TURBO] = turbo_q;
		reg_view[`VPS_BIT_MODE_HI:`VPS_BIT_MODE_LO] = strap_q.mode[1:0];
		reg_view[`VPS_BIT_REFCLK_DIR] = refclk_dir_q;
		reg_view[`VPS_BIT_CLK_DRIVE] = clk_drive_q;
		reg_view[`VPS_BIT_SPD_HI:`VPS_BIT_SPD_LO] = speed_duplex;
		reg_view[`VPS_BIT_HB_OFF] = hb_off_q;
	end

	assign sys_hit = sys_sel && (sys_rd || sys_wr);

	// read data registered; upper half padding reads zero
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			sys_rdata <= '0;
			mii_rdata <= '0;
		end else begin
			if (sys_rd) begin
				sys_rdata <= sys_sel ? {16'h0000, reg_view} : 32'h0000_0000;
			end
			if (mii_rd) begin
				mii_rdata <= mii_sel ? reg_view : 16'h0000;
			end
		end
	end

	// effective controls
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			ctrl_out                    <= '0;
			port_reference_clock_pin_oe <= 1'b0;
		end else begin
			port_reference_clock_pin_oe <= refclk_dir_q;
			ctrl_out.refclk_output      <= refclk_dir_q;
			ctrl_out.drive_16ma         <= clk_drive_q && ((strap_q.mode == VPS_RMII_MAC)
				|| (strap_q.mode == VPS_RMII_PHY)
				|| (strap_q.mode == VPS_MII_PHY && turbo_q));
			ctrl_out.heartbeat_test_en  <= (strap_q.mode == VPS_MII_PHY) && !hb_off_q;
			ctrl_out.turbo_active       <= (strap_q.mode == VPS_MII_PHY) && turbo_q;
		end
	end

	// defaults and resets
	strap_default_a: assert property (@(posedge mclk) disable iff (sys_rst)
		$rose(strap_take_q) |=> (hb_off_q == strap_q.hb_off))
		else $error("heartbeat bit missed strap default");
	vreset_a: assert property (@(posedge mclk) disable iff (sys_rst)
		(vphy_reset_pulse && strap_take_q) |=> (refclk_dir_q == strap_q.refclk_dir)
		&& (clk_drive_q == strap_q.clk_drive))
		else $error("vphy reset did not restore defaults");
	soft_hold_a: assert property (@(posedge mclk) disable iff (sys_rst)
		(vphy_soft_reset_bit && strap_take_q) |=> (hb_off_q == strap_q.hb_off)
		&& (turbo_q == strap_q.turbo))
		else $error("soft reset did not hold defaults");
	mode_stable_a: assert property (@(posedge mclk) disable iff (sys_rst)
		strap_take_q |=> $stable(strap_q))
		else $error("read-only mode field changed");

	// effective controls
	refclk_dir_a: assert property (@(posedge mclk) disable iff (sys_rst)
		##1 port_reference_clock_pin_oe == $past(refclk_dir_q))
		else $error("reference clock direction wrong");
	write_lands_a: assert property (@(posedge mclk) disable iff (sys_rst)
		(wr_any && !soft_reset) |=> refclk_dir_q == $past(wr_data[6]))
		else $error("clock direction write lost");
	drive_a: assert property (@(posedge mclk) disable iff (sys_rst)
		(strap_q.mode == VPS_MII_PHY && !turbo_q) [*2] |-> !ctrl_out.drive_16ma)
		else $error("drive not 12 mA in slow mii phy");
	drive_rmii_a: assert property (@(posedge mclk) disable iff (sys_rst)
		(clk_drive_q && (strap_q.mode == VPS_RMII_MAC || strap_q.mode == VPS_RMII_PHY))
		|=> ctrl_out.drive_16ma)
		else $error("rmii drive not 16 mA");
	hb_mode_a: assert property (@(posedge mclk) disable iff (sys_rst)
		(strap_q.mode != VPS_MII_PHY) [*2] |-> !ctrl_out.heartbeat_test_en)
		else $error("heartbeat active outside mii phy");
	hb_enable_a: assert property (@(posedge mclk) disable iff (sys_rst)
		(strap_q.mode == VPS_MII_PHY && !hb_off_q) |=> ctrl_out.heartbeat_test_en)
		else $error("heartbeat test not enabled in mii phy");

	// read view
	an_speed_a: assert property (@(posedge mclk) disable iff (sys_rst)
		vphy_autoneg_enable |-> reg_view[4:2] == an_result)
		else $error("negotiated speed/duplex not shown");
	forced_speed_a: assert property (@(posedge mclk) disable iff (sys_rst)
		!vphy_autoneg_enable |-> reg_view[4] == mode_a && reg_view[3] == vphy_speed_select_low
		&& reg_view[2] == !vphy_speed_select_low)
		else $error("forced speed/duplex mismatch");
	pad_zero_a: assert property (@(posedge mclk) disable iff (sys_rst)
		sys_rd |=> sys_rdata[31:16] == 16'h0000 && sys_rdata[1] == 1'b0)
		else $error("reserved bits not zero");
	mode_view_a: assert property (@(posedge mclk) disable iff (sys_rst)
		(mii_rd && mii_sel) |=> mii_rdata[15] == strap_q.mode[2]
		&& mii_rdata[9:8] == strap_q.mode[1:0])
		else $error("mode field mismatch");
	mii_view_a: assert property (@(posedge mclk) disable iff (sys_rst)
		(mii_rd && mii_sel) |=> mii_rdata == $past(reg_view))
		else $error("serial view not lower half");
	sys_view_a: assert property (@(posedge mclk) disable iff (sys_rst)
		(sys_rd && sys_sel) |=> sys_rdata == {16'h0000, $past(reg_view)})
		else $error("register-space view wrong");
	sys_miss_a: assert property (@(posedge mclk) disable iff (sys_rst)
		(sys_rd && !sys_sel) |=> sys_rdata == 32'h0000_0000)
		else $error("miss read not zero");
endmodule
`default_nettype wire

/* core/vps_sync.sv */
// vps_sync.sv: two-flop level synchroniser, parameter width
// assumes one clock, synchronous active-high reset
`timescale 1ns/1ps
`default_nettype none
module vps_sync #(
	parameter int W = 1
) (
	input  wire logic         mclk,
	input  wire logic         sys_rst,
	input  wire logic [W-1:0] din,
	output var  logic [W-1:0] dout
);
	logic [W-1:0] meta_q;

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			meta_q <= '0;
			dout   <= '0;
		end else begin
			meta_q <= din;
			dout   <= meta_q;
		end
	end
endmodule
`default_nettype wire

/* shared/vps_pkg.sv */
// vps_pkg.sv: types for the vphy special control/status register
// assumes vps_regs.svh for the numeric constants
`default_nettype none
package vps_pkg;
	typedef enum logic [2:0] {
		VPS_MII_MAC  = 3'b000,
		VPS_MII_PHY  = 3'b001,
		VPS_RMII_MAC = 3'b010,
		VPS_RMII_PHY = 3'b011,
		VPS_MODE_RSV = 3'b100
	} vps_mode_e;

	typedef struct packed {
		vps_mode_e  mode;
		logic       turbo;
		logic       refclk_dir;
		logic       clk_drive;
		logic       hb_off;
	} vps_strap_s;

	typedef struct packed {
		logic       refclk_output;
		logic       drive_16ma;
		logic       heartbeat_test_en;
		logic       turbo_active;
	} vps_ctrl_s;
endpackage
`default_nettype wire

/* shared/vps_regs.svh */
// vps_regs.svh: offsets, field positions and timing for the vphy special register
// assumes inclusion by bare name from the modules
`ifndef VPS_REGS_SVH
`define VPS_REGS_SVH
`define VPS_OFS_PORT0       12'h1dc
`define VPS_OFS_PORT1       12'h0dc
`define VPS_MII_INDEX       5'h1f
`define VPS_BIT_MODE2       15
`define VPS_BIT_TURBO       10
`define VPS_BIT_MODE_HI     9
`define VPS_BIT_MODE_LO     8
`define VPS_BIT_REFCLK_DIR  6
`define VPS_BIT_CLK_DRIVE   5
`define VPS_BIT_SPD_HI      4
`define VPS_BIT_SPD_LO      2
`define VPS_BIT_HB_OFF      0
`define VPS_SPD_10_HALF     3'h1
`define VPS_SPD_100_HALF    3'h2
`define VPS_SPD_10_FULL     3'h5
`define VPS_SPD_100_FULL    3'h6
`define VPS_SYNC_STAGES     2
`endif

/* tb/vps_host.sv */
// vps_host.sv: management host model on the serial register port
// assumes the bench clock; strobes change 1 ns after the rising edge
`timescale 1ns/1ps
`default_nettype none
`include "vps_regs.svh"
module vps_host (
	input  wire logic        mclk,
	output var  logic        mii_wr,
	output var  logic        mii_rd,
	output var  logic [4:0]  mii_regad,
	output var  logic [15:0] mii_wdata,
	input  wire logic [15:0] mii_rdata
);
	initial begin
		mii_wr = 1'b0;
		mii_rd = 1'b0;
		mii_regad = 5'h00;
		mii_wdata = 16'h0000;
	end
	// one-cycle strobe; released data shows the inverse so stale values never match
	task automatic access(input logic wr, input logic [15:0] wd, output logic [15:0] rd);
		@(posedge mclk);
		#1;
		mii_regad = `VPS_MII_INDEX;
		mii_wdata = wd;
		mii_wr = wr;
		mii_rd = !wr;
		@(posedge mclk);
		#1;
		mii_wr = 1'b0;
		mii_rd = 1'b0;
		mii_regad = 5'h00;
		mii_wdata = ~wd;
		rd = mii_rdata;
	endtask
endmodule
`default_nettype wire

/* tb/vps_special_reg_bench.sv */
// vps_special_reg_bench.sv: register-level bench for the vphy special register
// assumes vps_host drives the serial port; straps are latched on the third clock edge after reset release
`timescale 1ns/1ps
`default_nettype none
`include "vps_regs.svh"
module vps_special_reg_bench;
	import vps_pkg::*;
	logic mclk, sys_rst, rst_pulse, soft_rst, an_en, spd_lo, mode_a, lpbk, sys_wr, sys_rd, hit;
	logic mwr, mrd;
	logic [4:0] mad;
	logic [15:0] mwd, mrd_data, rd;
	logic [2:0] an_res;
	logic [2:0] exp_spd [4];
	logic [11:0] sys_addr;
	logic [31:0] sys_wdata, sys_rdata;
	vps_strap_s strap;
	vps_ctrl_s ctrl;
	logic oe;
	int fails, comparisons;
	vps_special_reg u_dut (.mclk(mclk), .sys_rst(sys_rst), .strap_pins(strap),
		.vphy_reset_pulse(rst_pulse), .vphy_soft_reset_bit(soft_rst),
		.vphy_autoneg_enable(an_en), .vphy_speed_select_low(spd_lo), .mode_a(mode_a),
		.an_result(an_res), .loopback_in(lpbk), .sys_wr(sys_wr), .sys_rd(sys_rd),
		.sys_addr(sys_addr), .sys_wdata(sys_wdata), .sys_rdata(sys_rdata), .sys_hit(hit),
		.mii_wr(mwr), .mii_rd(mrd), .mii_regad(mad), .mii_wdata(mwd), .mii_rdata(mrd_data),
		.ctrl_out(ctrl), .port_reference_clock_pin_oe(oe));
	vps_host u_host (.mclk(mclk), .mii_wr(mwr), .mii_rd(mrd), .mii_regad(mad),
		.mii_wdata(mwd), .mii_rdata(mrd_data));
	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			fails++;
			$display("Error t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic sys_acc(input logic wr, input logic [11:0] a, input logic [31:0] wd);
		@(posedge mclk);
		#1;
		sys_addr = a;
		sys_wdata = wd;
		sys_wr = wr;
		sys_rd = !wr;
		#1;
		chk({31'h0, hit}, {31'h0, a == `VPS_OFS_PORT0});
		@(posedge mclk);
		#1;
		sys_wr = 1'b0;
		sys_rd = 1'b0;
		sys_wdata = ~wd;
	endtask
	task automatic mii(input logic wr, input logic [15:0] wd);
		u_host.access(wr, wd, rd);
		repeat (3) @(posedge mclk);
		#1;
	endtask
	task automatic do_reset(input vps_strap_s s);
		strap = s;
		sys_rst = 1'b1;
		repeat (16) @(posedge mclk);
		#1;
		sys_rst = 1'b0;
		repeat (6) @(posedge mclk);
		#1;
	endtask
	task automatic conclude;
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	initial begin
		repeat (50000) @(posedge mclk);
		fails++;
		conclude;
	end
	initial begin
		{rst_pulse, soft_rst, spd_lo, mode_a, lpbk, sys_wr, sys_rd} = 7'h00;
		an_en = 1'b1;
		an_res = `VPS_SPD_100_FULL;
		sys_addr = 12'h000;
		sys_wdata = 32'h0;
		fails = 0;
		comparisons = 0;
		exp_spd = '{`VPS_SPD_10_HALF, `VPS_SPD_100_HALF, `VPS_SPD_10_FULL, `VPS_SPD_100_FULL};
		do_reset({VPS_RMII_PHY, 4'b0110});
		sys_acc(1'b0, `VPS_OFS_PORT0, 32'h0);
		chk(sys_rdata, 32'h0000_0378);
		sys_acc(1'b1, `VPS_OFS_PORT0, 32'hffff_ffff);
		sys_acc(1'b0, `VPS_OFS_PORT0, 32'h0);
		chk(sys_rdata, 32'h0000_0779);
		chk({29'h0, ctrl.refclk_output, ctrl.drive_16ma, oe}, 32'h7);
		chk({31'h0, ctrl.turbo_active}, 32'h0);
		sys_acc(1'b0, `VPS_OFS_PORT1, 32'h0);
		chk(sys_rdata, 32'h0);
		lpbk = 1'b1;
		sys_acc(1'b0, `VPS_OFS_PORT0, 32'h0);
		chk(sys_rdata, 32'h0000_4779);
		lpbk = 1'b0;
		mii(1'b1, 16'h0000);
		chk({29'h0, ctrl.refclk_output, ctrl.drive_16ma, oe}, 32'h0);
		mii(1'b0, 16'h0);
		chk({16'h0, rd}, 32'h0000_0318);
		an_en = 1'b0;
		for (int i = 0; i < 4; i++) begin
			{mode_a, spd_lo} = 2'(i);
			mii(1'b0, 16'h0);
			chk({29'h0, rd[4:2]}, {29'h0, exp_spd[i]});
		end
		an_en = 1'b1;
		rst_pulse = 1'b1;
		@(posedge mclk);
		#1;
		rst_pulse = 1'b0;
		mii(1'b0, 16'h0);
		chk({16'h0, rd}, 32'h0000_0378);
		soft_rst = 1'b1;
		mii(1'b1, 16'h0000);
		mii(1'b0, 16'h0);
		chk({16'h0, rd}, 32'h0000_0378);
		soft_rst = 1'b0;
		do_reset({VPS_MII_PHY, 4'b0011});
		mii(1'b0, 16'h0);
		chk({16'h0, rd}, 32'h0000_0139);
		chk({30'h0, ctrl.drive_16ma, ctrl.heartbeat_test_en}, 32'h0);
		mii(1'b1, 16'h0020);
		chk({30'h0, ctrl.drive_16ma, ctrl.heartbeat_test_en}, 32'h1);
		mii(1'b1, 16'h0420);
		chk({30'h0, ctrl.drive_16ma, ctrl.heartbeat_test_en}, 32'h3);
		chk({31'h0, ctrl.turbo_active}, 32'h1);
		conclude;
	end
endmodule
`default_nettype wire
